// ==== flash_sec_pkg.sv ====
/*
 * Package for the flash security gate and clock divider: register offsets,
 * field positions, reset values, security codes and shared carrier structs.
 * Assumes a 32-bit APB slave with one byte-wide register per aligned word.
 */
package flash_sec_pkg;

	// Register byte offsets
	localparam logic [11:0] off_clock_divider   = 12'h000;
	localparam logic [11:0] off_config          = 12'h004;
	localparam logic [11:0] off_option          = 12'h008;
	localparam logic [11:0] off_protection      = 12'h00C;
	localparam logic [11:0] off_status          = 12'h010;
	localparam logic [11:0] off_key_stored_lo   = 12'h014;
	localparam logic [11:0] off_key_stored_hi   = 12'h018;
	localparam logic [11:0] off_key_entry       = 12'h01C;
	localparam logic [11:0] off_blank_result    = 12'h020;

	// Divider register fields
	localparam int          pos_divisor_loaded_flag           = 7;
	localparam int          pos_prescale        = 6;
	localparam int          divisor_width       = 6;
	localparam logic [7:0]  clock_divider_reset = 8'h00;
	localparam logic [2:0]  prescale_count_max  = 3'h7;

	// Option register fields
	localparam int          pos_backdoor_enable = 7;
	localparam logic [7:0]  option_reserved_mask = 8'hC3;

	// Config register fields
	localparam int          pos_key_write_access = 5;
	localparam logic [7:0]  config_write_mask    = 8'hE0;
	localparam logic [7:0]  config_reset         = 8'h00;

	// Security codes
	localparam logic [1:0]  security_code_unsecured = 2'h2;

	// Backdoor key
	localparam int          key_bytes            = 8;
	localparam logic [3:0]  key_index_full       = 4'h8;

	// Status register bit positions
	localparam int          pos_stat_secure      = 0;
	localparam int          pos_stat_erase_ok    = 1;
	localparam int          pos_stat_debug_ok    = 2;
	localparam int          pos_stat_bgnd_ok     = 3;
	localparam int          pos_stat_key_cnt     = 4;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        from_secure;
		logic        from_debug;
	} mem_access_t;

	typedef struct packed {
		logic        prescale_by_eight;
		logic [5:0]  divisor_field;
	} divider_setting_t;

endpackage

// ==== flash_clock_divider.sv ====
/*
 * Flash clock divider: optional divide by eight, then divide by divisor+1.
 * Emits a one-cycle tick per internal flash clock period and a timing pulse
 * count. Assumes the setting is static once loaded and enable is a level.
 */
`timescale 1ns/10ps
module flash_clock_divider (
	// Clock and reset
	input  wire logic                             pclk,
	input  wire logic                             presetn,
	// Control
	input  wire logic                             enable,
	input  wire flash_sec_pkg::divider_setting_t  setting,
	// Timebase
	output logic                                  flash_clk_tick,
	output logic [15:0]                           pulse_count
);
	import flash_sec_pkg::*;

	logic [2:0]  pre_q;
	logic [2:0]  pre_d;
	logic [5:0]  div_q;
	logic [5:0]  div_d;
	logic [15:0] pulses_q;
	logic        tick_q;
	wire         pre_tick;
	wire         div_wrap;

	// Prescaler stage advances the divider every eighth edge when prescale_by_eight is set, every edge otherwise
	assign pre_tick = setting.prescale_by_eight ?
		(pre_q == prescale_count_max) : 1'b1;
	assign pre_d    = enable ? pre_q + 3'h1 : 3'h0;
	assign div_wrap = pre_tick && (div_q == setting.divisor_field);
	assign div_d    = !enable ? 6'h00 :
		(div_wrap ? 6'h00 : (pre_tick ? div_q + 6'h01 : div_q));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q    <= 3'h0;
			div_q    <= 6'h00;
			tick_q   <= 1'b0;
			pulses_q <= 16'h0000;
		end else begin
			pre_q    <= pre_d;
			div_q    <= div_d;
			tick_q   <= enable && div_wrap;
			// One timing pulse is exactly one flash clock period
			if (enable && div_wrap)
				pulses_q <= pulses_q + 16'h0001;
		end
	end

	assign flash_clk_tick = tick_q;
	assign pulse_count    = pulses_q;

endmodule

// ==== flash_security.sv ====
/*
 * Flash security gate with backdoor key, blank-check unlock, protection
 * register guard and the write-once flash clock divider register.
 * Assumes an APB master for registers, a memory access port from the CPU
 * and debug controller, and a static option byte and key from storage.
 */
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/10ps
module flash_security (
	// Clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic                             pready,
	output logic [31:0]                      prdata,
	output logic                             pslverr,
	input  wire logic                        apb_from_debug,
	// Nonvolatile storage
	input  wire logic [7:0]                  nonvolatile_option_byte,
	input  wire logic [63:0]                 backdoor_key_bytes,
	// Memory access port
	input  wire flash_sec_pkg::mem_access_t  mem_req,
	input  wire logic [7:0]                  mem_wdata_in,
	input  wire logic [7:0]                  mem_rdata_in,
	output logic                             mem_write_allow,
	output logic [7:0]                       mem_rdata_out,
	// Key location writes
	input  wire logic                        key_loc_write,
	input  wire logic                        key_loc_from_secure,
	input  wire logic [2:0]                  key_loc_index,
	input  wire logic [7:0]                  key_loc_data,
	output logic                             command_start,
	// Blank check result
	input  wire logic                        blank_check_done,
	input  wire logic                        blank_check_erased,
	// Debug and background mode
	input  wire logic                        debug_enable_req,
	input  wire logic                        background_mode_pin,
	input  wire logic                        background_entry_req,
	output logic                             debug_enable,
	output logic                             background_entry_allow,
	// Flash timing and security state
	output logic                             erase_program_enable,
	output logic                             flash_clk_tick,
	output logic [15:0]                      pulse_count,
	output logic                             secure
);
	import flash_sec_pkg::*;

	logic [7:0]  option_q;
	logic        option_loaded_q;
	logic [7:0]  config_q;
	logic [7:0]  protection_q;
	logic [7:0]  divider_q;
	logic [63:0] key_entry_q;
	logic [3:0]  key_count_q;
	logic        key_order_ok_q;
	logic        key_prev_write_q;
	logic        unlocked_q;
	logic        bkgd_strap_q;
	logic        strap_taken_q;
	logic [7:0]  last_key_q;
	logic        blank_ok_q;

	wire         apb_access;
	wire         apb_wr;
	wire         sel_divider;
	wire         sel_config;
	wire         sel_option;
	wire         sel_protection;
	wire         sel_status;
	wire         sel_key_lo;
	wire         sel_key_hi;
	wire         sel_key_entry;
	wire         sel_blank;
	wire         addr_mapped;
	wire         key_access;
	wire         backdoor_enabled;
	wire         code_unsecured;
	wire         key_write_ok;
	wire         key_access_clear;
	wire         key_match;
	wire         mem_blocked;
	wire [7:0]   status_word;
	wire [7:0]   read_byte;
	wire         divider_wr;
	divider_setting_t div_setting;

	// Bus decode
	assign apb_access     = psel && penable;
	assign apb_wr         = apb_access && pwrite;
	assign sel_divider    = (paddr == off_clock_divider);
	assign sel_config     = (paddr == off_config);
	assign sel_option     = (paddr == off_option);
	assign sel_protection = (paddr == off_protection);
	assign sel_status     = (paddr == off_status);
	assign sel_key_lo     = (paddr == off_key_stored_lo);
	assign sel_key_hi     = (paddr == off_key_stored_hi);
	assign sel_key_entry  = (paddr == off_key_entry);
	assign sel_blank      = (paddr == off_blank_result);
	assign addr_mapped    = sel_divider | sel_config | sel_option |
		sel_protection | sel_status | sel_key_lo | sel_key_hi |
		sel_key_entry | sel_blank;
	assign pready         = 1'b1;
	assign pslverr        = apb_access && !addr_mapped;

	// Security state
	assign key_access       = config_q[pos_key_write_access];
	assign backdoor_enabled = option_q[pos_backdoor_enable];
	assign code_unsecured   = (option_q[1:0] == security_code_unsecured);
	assign secure           = !code_unsecured;

	// Key entry: secure code only, enabled backdoor, ascending order
	assign key_write_ok = key_loc_write && key_access && backdoor_enabled &&
		key_loc_from_secure;
	assign command_start = key_loc_write && !key_access;
	assign key_access_clear = apb_wr && sel_config && key_access &&
		!pwdata[pos_key_write_access] && !apb_from_debug;
	assign key_match = (key_count_q == key_index_full) && key_order_ok_q &&
		(key_entry_q == backdoor_key_bytes);

	// Memory gate
	assign mem_blocked = secure &&
		(mem_req.from_debug || !mem_req.from_secure);
	assign mem_write_allow = mem_req.valid && mem_req.write && !mem_blocked;
	assign mem_rdata_out   = mem_blocked ? 8'h00 : mem_rdata_in;

	// Debug and background mode gating
	assign debug_enable = debug_enable_req && !secure;
	assign background_entry_allow = background_entry_req &&
		(!secure || bkgd_strap_q);

	// Program and erase only after the divider is loaded
	assign erase_program_enable = divider_q[pos_divisor_loaded_flag];

	assign div_setting.prescale_by_eight = divider_q[pos_prescale];
	assign div_setting.divisor_field     = divider_q[divisor_width-1:0];
	assign divider_wr = apb_wr && sel_divider && !divider_q[pos_divisor_loaded_flag];

	assign status_word = {1'b0,
		key_count_q[2:0], background_entry_allow, debug_enable,
		erase_program_enable, secure};

	assign read_byte =
		sel_divider    ? divider_q :
		sel_config     ? (config_q & config_write_mask) :
		sel_option     ? (option_q & option_reserved_mask) :
		sel_protection ? protection_q :
		sel_status     ? status_word :
		sel_blank      ? {7'h00, blank_ok_q} :
		8'h00;

	// Option register: loaded on the first edge after reset, bus writes ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			option_loaded_q <= 1'b0;
			option_q        <= 8'h00;
		end else if (!option_loaded_q) begin
			option_loaded_q <= 1'b1;
			option_q        <= nonvolatile_option_byte;
		end else if ((key_access_clear && backdoor_enabled && key_match) ||
			(blank_check_done && blank_check_erased)) begin
			option_q[1:0] <= security_code_unsecured;
		end
	end

	// Strap of the background mode pin, caught at release of reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_taken_q <= 1'b0;
			bkgd_strap_q  <= 1'b0;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			bkgd_strap_q  <= !background_mode_pin;
		end
	end

	// Configuration and protection registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_q     <= config_reset;
			protection_q <= 8'h00;
		end else begin
			if (apb_wr && sel_config)
				config_q <= pwdata[7:0] & config_write_mask;
			// Application software cannot loosen protection
			if (!option_loaded_q)
				protection_q <= 8'hFF;
			else if (apb_wr && sel_protection && apb_from_debug)
				protection_q <= pwdata[7:0];
		end
	end

	// Write-once divider register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			divider_q <= clock_divider_reset;
		else if (divider_wr)
			divider_q <= {1'b1, pwdata[6:0]};
	end

	// Key comparison capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_entry_q      <= 64'h0000000000000000;
			key_count_q      <= 4'h0;
			key_order_ok_q   <= 1'b1;
			key_prev_write_q <= 1'b0;
			last_key_q       <= 8'h00;
		end else begin
			key_prev_write_q <= key_loc_write;
			if (key_access_clear || !key_access) begin
				// Mismatch simply discards the entry
				key_count_q    <= 4'h0;
				key_order_ok_q <= 1'b1;
			end else if (key_write_ok) begin
				// Adjacent writes or out of order spoil the entry
				if (key_prev_write_q ||
					({1'b0, key_loc_index} != key_count_q))
					key_order_ok_q <= 1'b0;
				if (key_count_q != key_index_full)
					key_count_q <= key_count_q + 4'h1;
				key_entry_q <= {key_entry_q[55:0], key_loc_data};
				last_key_q  <= key_loc_data;
			end
		end
	end

	// Blank check outcome held for software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			blank_ok_q <= 1'b0;
		else if (blank_check_done)
			blank_ok_q <= blank_check_erased;
	end

	// Read data registered at the edge that ends the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= {24'h000000, read_byte};
	end

	flash_clock_divider u_divider (
		.pclk           (pclk),
		.presetn        (presetn),
		.enable         (divider_q[pos_divisor_loaded_flag]),
		.setting        (div_setting),
		.flash_clk_tick (flash_clk_tick),
		.pulse_count    (pulse_count)
	);

	wire unused_ok = &{1'b0, mem_wdata_in, sel_key_lo, sel_key_hi,
		sel_key_entry};

endmodule

// ==== flash_security_assertions.sv ====
/*
 * Checker for the flash security gate: memory blocking, debug gating,
 * divisor loaded flag and unlock causes.
 * Assumes binding to flash_security; sees only its ports.
 */
`timescale 1ns/10ps
module flash_security_assertions
	import flash_sec_pkg::*;
(
	// Clock and reset
	input wire logic                       pclk,
	input wire logic                       presetn,
	// Bus and storage side
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [11:0]                paddr,
	input wire logic                       blank_check_done,
	input wire logic                       blank_check_erased,
	// Memory request, read data and gate outputs
	input wire flash_sec_pkg::mem_access_t mem_req,
	input wire logic [7:0]                 mem_rdata_in,
	input wire logic                       mem_write_allow,
	input wire logic [7:0]                 mem_rdata_out,
	input wire logic                       debug_enable,
	input wire logic                       erase_program_enable,
	input wire logic                       secure
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire blocked = secure && mem_req.valid
		&& (!mem_req.from_secure || mem_req.from_debug);
	sequence s_div_wr;
		psel && penable && pwrite && paddr == off_clock_divider;
	endsequence
	sequence s_cfg_wr;
		psel && penable && pwrite && paddr == off_config;
	endsequence
	a_block_write: assert property (blocked |-> !mem_write_allow)
		else $error("blocked write passed");
	a_block_read: assert property (blocked |-> mem_rdata_out == 8'h00)
		else $error("blocked read not zero");
	a_pass_read: assert property (mem_req.valid && !blocked
		|-> mem_rdata_out == mem_rdata_in)
		else $error("allowed read altered");
	a_debug_gate: assert property (secure |-> !debug_enable)
		else $error("debug enabled while secure");
	a_load_cause: assert property ($rose(erase_program_enable)
		|-> $past(psel && penable && pwrite && paddr == off_clock_divider))
		else $error("flag set without divider write");
	a_load_sticky: assert property (s_div_wr |=> erase_program_enable[*8])
		else $error("flag not set after write");
	a_unlock_hold: assert property (!secure |=> !secure)
		else $error("security returned before reset");
	a_blank_unlock: assert property (blank_check_done && blank_check_erased
		|=> !secure)
		else $error("blank check did not unlock");
	a_unlock_cause: assert property ($fell(secure) |->
		$past(blank_check_done && blank_check_erased) ||
		$past(psel && penable && pwrite && paddr == off_config)
		|| !$past(presetn, 2) || !$past(presetn, 3))
		else $error("security dropped without cause");
endmodule
bind flash_security flash_security_assertions a_inst (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .blank_check_done,
	.blank_check_erased, .mem_req, .mem_rdata_in, .mem_write_allow,
	.mem_rdata_out, .debug_enable, .erase_program_enable, .secure);

// ==== flash_array_model.sv ====
/*
 * Memory cell and blank check engine behind the gate.
 * Assumes the bench requests blank checks; idle reads show a toggling byte.
 */
`timescale 1ns/10ps
module flash_array_model (
	// Clock and reset
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// Access from the gate
	input  wire flash_sec_pkg::mem_access_t mem_req,
	input  wire logic                       mem_write_allow,
	input  wire logic [7:0]                 mem_wdata_in,
	output logic [7:0]                      mem_rdata_in,
	// Blank check request
	input  wire logic                       check_go,
	input  wire logic                       check_erased,
	output logic                            blank_check_done,
	output logic                            blank_check_erased
);
	import flash_sec_pkg::*;
	logic [7:0] cell_q;
	logic [7:0] junk_q;
	// Idle data toggles so a stale byte never passes for a real read
	assign mem_rdata_in = (mem_req.valid && !mem_req.write) ? cell_q : junk_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cell_q <= 8'h00;
			junk_q <= 8'h5A;
			blank_check_done <= 1'b0;
			blank_check_erased <= 1'b0;
		end else begin
			if (mem_write_allow)
				cell_q <= mem_wdata_in;
			junk_q <= ~junk_q;
			blank_check_done <= check_go;
			blank_check_erased <= check_go & check_erased;
		end
	end
endmodule

// ==== test_flash_security.sv ====
/*
 * Self-checking bench for flash_security: divider, codes, key, blank check.
 * Assumes flash_array_model as memory and a 25 MHz bus clock.
 */
`timescale 1ns/10ps
`define chk(n,e,s) begin checks_done++; if ((s) !== (e)) begin \
mismatches++; $display("mismatch %s exp %h got %h", n, e, s); end end
module test_flash_security;
	import flash_sec_pkg::*;
	localparam logic [63:0] key = 64'h1122334455667788;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        err, apb_from_debug, command_start, check_go, check_erased;
	logic        key_loc_write, key_loc_from_secure, debug_enable_req;
	logic        background_mode_pin, background_entry_req, debug_enable;
	logic        background_entry_allow, erase_program_enable, secure;
	logic        mem_write_allow, flash_clk_tick, blank_check_done;
	logic        blank_check_erased;
	logic [2:0]  key_loc_index;
	logic [7:0]  key_loc_data, mem_wdata_in, mem_rdata_in, mem_rdata_out;
	logic [7:0]  nonvolatile_option_byte;
	logic [11:0] paddr;
	logic [15:0] pulse_count;
	logic [31:0] pwdata, prdata, r;
	mem_access_t mem_req;
	int          mismatches, checks_done, n;
	flash_security flash_security_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.apb_from_debug, .nonvolatile_option_byte,
		.backdoor_key_bytes(key), .mem_req, .mem_wdata_in, .mem_rdata_in,
		.mem_write_allow, .mem_rdata_out, .key_loc_write,
		.key_loc_from_secure, .key_loc_index, .key_loc_data, .command_start,
		.blank_check_done, .blank_check_erased, .debug_enable_req,
		.background_mode_pin, .background_entry_req, .debug_enable,
		.background_entry_allow, .erase_program_enable, .flash_clk_tick,
		.pulse_count, .secure);
	flash_array_model flash_array_model_inst (.pclk, .presetn, .mem_req,
		.mem_write_allow, .mem_wdata_in, .mem_rdata_in, .check_go,
		.check_erased, .blank_check_done, .blank_check_erased);
	task automatic conclude;
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic settle;
		@(posedge pclk);
		#1;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		// Start on a rising edge even when called after a settle delay
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin mismatches++; conclude(); end
		r = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic rst(input logic [7:0] opt, input logic pin);
		presetn <= 1'b0; nonvolatile_option_byte <= opt;
		background_mode_pin <= pin;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask
	task automatic wait_tick;
		n = 0;
		do begin @(posedge pclk); n++; end
		while (flash_clk_tick !== 1'b1 && n < 300);
		if (n >= 300) begin mismatches++; conclude(); end
	endtask
	task automatic t_codes;
		for (int c = 0; c < 4; c++) begin
			rst({6'h00, 2'(c)}, 1'b1);
			`chk("secure", c != 2, secure)
			`chk("debug", c == 2, debug_enable)
			`chk("bgnd", c == 2, background_entry_allow)
			apb(1'b1, off_option, 32'hFF);
			apb(1'b0, off_option, 32'h0);
			`chk("option", 32'(c), r)
		end
		rst(8'h83, 1'b0);
		`chk("bgnd strap", 1'b1, background_entry_allow)
		apb(1'b0, 12'h040, 32'h0);
		`chk("unmapped", 1'b1, err)
	endtask
	task automatic t_divider;
		apb(1'b0, off_clock_divider, 32'h0);
		`chk("div reset", 32'h0, r)
		`chk("ep off", 1'b0, erase_program_enable)
		apb(1'b1, off_clock_divider, 32'h4C);
		apb(1'b1, off_clock_divider, 32'h05);
		apb(1'b0, off_clock_divider, 32'h0);
		`chk("div", 32'hCC, r)
		`chk("ep on", 1'b1, erase_program_enable)
		wait_tick();
		wait_tick();
		`chk("tick period", 104, n)
		apb(1'b1, off_protection, 32'h00);
		apb(1'b0, off_protection, 32'h0);
		`chk("prot app", 32'hFF, r)
		apb_from_debug <= 1'b1;
		apb(1'b1, off_protection, 32'h00);
		apb_from_debug <= 1'b0;
		apb(1'b0, off_protection, 32'h0);
		`chk("prot dbg", 32'h0, r)
	endtask
	task automatic t_key(input logic [7:0] opt, input logic [63:0] k,
		input logic sec, input logic exp);
		rst(opt, 1'b1);
		key_loc_write <= 1'b1;
		settle();
		`chk("cmd start", 1'b1, command_start)
		key_loc_write <= 1'b0;
		apb(1'b1, off_config, 32'h20);
		// Gap cycle after each byte: adjacent writes spoil entry
		for (int i = 0; i < key_bytes; i++) begin
			key_loc_write <= 1'b1; key_loc_index <= 3'(i);
			key_loc_data <= k[63 - 8 * i -: 8]; key_loc_from_secure <= sec;
			settle();
			`chk("no cmd", 1'b0, command_start)
			key_loc_write <= 1'b0;
			@(posedge pclk);
		end
		apb(1'b1, off_config, 32'h00);
		settle();
		`chk("key secure", exp, secure)
	endtask
	task automatic t_blank;
		rst(8'h83, 1'b1);
		mem_wdata_in <= 8'hA5; mem_req <= 4'b1110;
		settle();
		mem_req <= 4'b1000;
		settle();
		`chk("blocked rd", 8'h00, mem_rdata_out)
		mem_req <= 4'b1010;
		settle();
		`chk("secure rd", 8'hA5, mem_rdata_out)
		check_go <= 1'b1; check_erased <= 1'b0;
		@(posedge pclk);
		check_go <= 1'b0;
		repeat (2) settle();
		`chk("not blank", 1'b1, secure)
		check_go <= 1'b1; check_erased <= 1'b1; mem_req <= 4'b1001;
		@(posedge pclk);
		check_go <= 1'b0;
		repeat (2) settle();
		`chk("blank", 1'b0, secure)
		`chk("dbg rd", 8'hA5, mem_rdata_out)
	endtask
	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, apb_from_debug, check_go} = '0;
		{check_erased, key_loc_write, key_loc_from_secure} = '0;
		{paddr, pwdata, key_loc_index, key_loc_data, mem_wdata_in} = '0;
		{mem_req, nonvolatile_option_byte, background_mode_pin} = '0;
		{debug_enable_req, background_entry_req} = 2'h3;
		mismatches = 0;
		checks_done = 0;
		t_codes();
		t_divider();
		t_key(8'h83, ~key, 1'b1, 1'b1);
		t_key(8'h83, key, 1'b0, 1'b1);
		t_key(8'h03, key, 1'b1, 1'b1);
		t_key(8'h83, key, 1'b1, 1'b0);
		t_blank();
		conclude();
	end
endmodule
